// ===== sim/cmpctl_monitor.sv
`timescale 1ns/1ps
module cmpctl_mon #(
   parameter int NCH = 3
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_page_in,
   input wire logic sfr_wr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic [7:0] sfr_rdata_out,
   input wire logic [NCH-1:0] ext_irq_enable_in,
   input wire logic [NCH-1:0] cmp_raw_in,
   input wire logic [NCH-1:0] channel_on_out,
   input wire logic [NCH-1:0] pin_out,
   input wire logic [NCH-1:0] irq_out
);
   import cmpctl_pkg::*;
   // ****************
   // Channel 0 checks, plus the mode read mask check at 0x89 on every page
   // ****************
   logic c0;
   assign c0 = sfr_addr_in == 8'h88 && sfr_page_in == 8'h01;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   property p_on; sfr_wr_in && c0 |=> channel_on_out[0] == $past(sfr_wdata_in[7]);
   endproperty
   property p_off; !channel_on_out[0] && !$past(channel_on_out[0]) |-> !pin_out[0];
   endproperty
   // Eight stable samples cover the synchronizer plus a re-enable
   property p_pin; (channel_on_out[0] && $stable(cmp_raw_in[0]))[*8] |-> pin_out[0] == cmp_raw_in[0];
   endproperty
   property p_out; c0 && channel_on_out[0] && $past(channel_on_out[0]) |-> sfr_rdata_out[6] == pin_out[0];
   endproperty
   property p_rise; c0 && $rose(pin_out[0]) |-> sfr_rdata_out[5];
   endproperty
   property p_fall; c0 && channel_on_out[0] && $fell(pin_out[0]) |-> sfr_rdata_out[4];
   endproperty
   property p_irq; !ext_irq_enable_in[0] && !$past(ext_irq_enable_in[0]) |-> !irq_out[0];
   endproperty
   property p_md0; sfr_addr_in == 8'h89 |-> (sfr_rdata_out & 8'hCC) == 8'h00;
   endproperty
   a_on: assert property (p_on) else $error("enable not applied");
   a_off: assert property (p_off) else $error("pin high while off");
   a_pin: assert property (p_pin) else $error("pin not following input");
   a_out: assert property (p_out) else $error("state bit wrong");
   a_rise: assert property (p_rise) else $error("rise flag missing");
   a_fall: assert property (p_fall) else $error("fall flag missing");
   a_irq: assert property (p_irq) else $error("request without enable");
   a_md0: assert property (p_md0) else $error("unused mode bits set");
   c_rise: cover property (c0 && sfr_rdata_out[5]);
   c_irq: cover property (irq_out[0]);
   c_fall: cover property ($fell(pin_out[0]));
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import cmpctl_pkg::*;
   // ****************
   // Bench
   // ****************
   logic clk = 0, rst = 1, wr = 0;
   logic [7:0] addr = 8'h00, page = 8'h00, wd = 8'h00, rdata;
   logic [2:0] ext = 3'h0, raw = 3'h0, on, pin, irq;
   cmpctl_resp_t md [3];
   cmpctl_hyst_t hp [3], hn [3];
   int n_mismatch = 0, check_count = 0, cyc = 0;
   cmpctl_top cmpctl_top_i (.core_clk_in(clk), .rst_in(rst), .sfr_addr_in(addr),
      .sfr_page_in(page), .sfr_wr_in(wr), .sfr_wdata_in(wd), .sfr_rdata_out(rdata),
      .ext_irq_enable_in(ext), .cmp_raw_in(raw), .channel_on_out(on),
      .positive_hysteresis_sel_out(hp), .negative_hysteresis_sel_out(hn),
      .response_mode_sel_out(md), .pin_out(pin), .irq_out(irq));
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Runaway guard, the tests need under a hundred cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      page = p;
      wd = d;
      wr = 1;
      @(negedge clk);
      wr = 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] p, input logic [7:0] e);
      @(negedge clk);
      addr = a;
      page = p;
      #10;
      chk(rdata, e);
   endtask
   task automatic t_regs();
      for (int p = 1; p < 4; p++) begin
         rd(8'h88, 8'(p), 8'h00);
         rd(8'h89, 8'(p), 8'h02);
      end
      for (int i = 0; i < 4; i++) begin
         int p;
         p = i % 3 + 1;
         wreg(8'h89, 8'(p), 8'hFC | 8'(i));
         rd(8'h89, 8'(p), 8'h30 | 8'(i));
         chk({6'h0, md[p-1]}, 8'(i));
         wreg(8'h88, 8'(p), 8'hC0 | 8'(i * 5));
         rd(8'h88, 8'(p), 8'h80 | 8'(i * 5));
         chk({4'h0, hp[p-1], hn[p-1]}, 8'(i * 5));
      end
      wreg(8'h88, 8'h02, 8'h00);
      chk({5'h0, on}, 8'h05);
      wreg(8'h88, 8'h04, 8'h00);
      chk({5'h0, on}, 8'h05);
      rd(8'h8A, 8'h01, 8'h00);
      $display("register test done");
   endtask
   task automatic t_edge();
      rd(8'h88, 8'h01, 8'h8F);
      ext = 3'h1;
      raw = 3'h1;
      repeat (8) @(negedge clk);
      rd(8'h88, 8'h01, 8'hEF);
      chk({2'h0, pin, irq}, 8'h09);
      ext = 3'h0;
      repeat (2) @(negedge clk);
      chk({5'h0, irq}, 8'h00);
      ext = 3'h1;
      wreg(8'h89, 8'h01, 8'h13);
      wreg(8'h88, 8'h01, 8'h9F);
      rd(8'h88, 8'h01, 8'hCF);
      raw = 3'h0;
      repeat (8) @(negedge clk);
      rd(8'h88, 8'h01, 8'h9F);
      chk({5'h0, irq}, 8'h01);
      wreg(8'h89, 8'h01, 8'h23);
      chk({5'h0, irq}, 8'h00);
      wreg(8'h88, 8'h01, 8'h1F);
      raw = 3'h1;
      repeat (8) @(negedge clk);
      rd(8'h88, 8'h01, 8'h1F);
      chk({5'h0, pin}, 8'h00);
      wreg(8'h88, 8'h01, 8'h0F);
      rd(8'h88, 8'h01, 8'h0F);
      $display("edge test done");
   endtask
   initial begin
      repeat (6) @(negedge clk);
      rst = 0;
      t_regs();
      t_edge();
      complete_run();
   end
endmodule
bind cmpctl_top cmpctl_mon #(.NCH(NCH)) cmpctl_mon_i (.core_clk_in(core_clk_in),
   .rst_in(rst_in), .sfr_addr_in(sfr_addr_in), .sfr_page_in(sfr_page_in),
   .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
   .ext_irq_enable_in(ext_irq_enable_in), .cmp_raw_in(cmp_raw_in),
   .channel_on_out(channel_on_out), .pin_out(pin_out), .irq_out(irq_out));

// ===== src/cmpctl_params.svh
// How it works
// - Three comparator channels, each switched on or off independently.
// - A channel that is off drives its pin output low.
// - Control bit 7 turns the channel on when 1, off when 0.
// - Control bit 6 reads the live synchronized comparator result.
// - A rising output transition sets control bit 5, the rise flag.
// - A falling output transition while the channel is on sets control bit 4, the fall flag.
// - Edge flags stay set until software clears them; hardware never clears.
// - Mode bit 5 enables rise requests, bit 4 enables fall requests.
// - A request reaches the core only if the extended enable bit is set.
// - Control bits 3-2 select positive hysteresis: none, 5, 10, 20 mV.
// - Control bits 1-0 select negative hysteresis: none, 5, 10, 20 mV.
// - Mode bits 1-0 select response mode, 00 fastest, 11 lowest power.
// - Mode bits 7-6 and 3-2 read zero and ignore writes.
// - Control registers decode at 0x88 on pages 1, 2 and 3.
// - Mode registers decode at 0x89 on pages 1, 2 and 3.
`ifndef CMPCTL_PARAMS_SVH
`define CMPCTL_PARAMS_SVH
`define CMPCTL_ADDR_CTRL 8'h88
`define CMPCTL_ADDR_MODE 8'h89
`define CMPCTL_PAGE_CH0 8'h01
`define CMPCTL_CTRL_RST 8'h00
`define CMPCTL_MODE_RST 8'h02
`define CMPCTL_BIT_EN 7
`define CMPCTL_BIT_OUT 6
`define CMPCTL_BIT_RISE 5
`define CMPCTL_BIT_FALL 4
`define CMPCTL_BIT_RIE 5
`define CMPCTL_BIT_FIE 4
`define CMPCTL_MODE_MASK 8'h33
`endif

// ===== src/cmpctl_pkg.sv
package cmpctl_pkg;
   typedef logic [1:0] cmpctl_hyst_t;
   typedef enum logic [1:0] {
      CMPCTL_MODE_FAST = 2'b00,
      CMPCTL_MODE_MID1 = 2'b01,
      CMPCTL_MODE_MID2 = 2'b10,
      CMPCTL_MODE_LOWP = 2'b11
   } cmpctl_resp_t;
endpackage

// ===== src/cmpctl_top.sv
`timescale 1ns/1ps
`include "cmpctl_params.svh"
module cmpctl_top #(
   parameter int NCH = 3
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Special-function register access
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_page_in,
   input wire logic sfr_wr_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] sfr_rdata_out,
   // Extended interrupt enable bits for comparator sources
   input wire logic [NCH-1:0] ext_irq_enable_in,
   // Analog comparator side
   input wire logic [NCH-1:0] cmp_raw_in,
   output logic [NCH-1:0] channel_on_out,
   output cmpctl_pkg::cmpctl_hyst_t positive_hysteresis_sel_out [NCH],
   output cmpctl_pkg::cmpctl_hyst_t negative_hysteresis_sel_out [NCH],
   output cmpctl_pkg::cmpctl_resp_t response_mode_sel_out [NCH],
   // Pin and interrupt outputs
   output logic [NCH-1:0] pin_out,
   output logic [NCH-1:0] irq_out
);
   import cmpctl_pkg::*;

   // ************************************************
   // Register state
   // ************************************************
   logic [NCH-1:0] channel_on_q;
   logic [NCH-1:0] rise_event_flag_q;
   logic [NCH-1:0] fall_event_flag_q;
   logic [NCH-1:0] rise_irq_enable_q;
   logic [NCH-1:0] fall_irq_enable_q;
   cmpctl_hyst_t pos_hyst_q [NCH];
   cmpctl_hyst_t neg_hyst_q [NCH];
   cmpctl_resp_t resp_q [NCH];
   logic [NCH-1:0] sync1_q;
   logic [NCH-1:0] sync2_q;
   logic [NCH-1:0] sync3_q;
   logic [NCH-1:0] result_state_flag_q;
   logic [NCH-1:0] ctrl_sel;
   logic [NCH-1:0] mode_sel;
   logic [NCH-1:0] rise_evt;
   logic [NCH-1:0] fall_evt;

   // Page n+1 holds channel n
   function automatic logic page_hit(input logic [7:0] page, input int ch);
      page_hit = (page == (`CMPCTL_PAGE_CH0 + 8'(ch)));
   endfunction

   // ************************************************
   // Address decode
   // ************************************************
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         ctrl_sel[i] = (sfr_addr_in == `CMPCTL_ADDR_CTRL) && page_hit(sfr_page_in, i);
         mode_sel[i] = (sfr_addr_in == `CMPCTL_ADDR_MODE) && page_hit(sfr_page_in, i);
      end
   end

   // ************************************************
   // Input synchronizer and edge detect
   // ************************************************
   // A change counts only once the second and third stages agree, so a
   // metastable first stage never reaches the flags.
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
         result_state_flag_q <= '0;
      end else begin
         sync1_q <= cmp_raw_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         for (int i = 0; i < NCH; i++) begin
            // Disabled channel reads low; its analog output is not valid
            if (!channel_on_q[i]) begin
               result_state_flag_q[i] <= 1'b0;
            end else if (sync2_q[i] == sync3_q[i]) begin
               result_state_flag_q[i] <= sync3_q[i];
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         rise_evt[i] = channel_on_q[i] && (sync2_q[i] == sync3_q[i])
                       && sync3_q[i] && !result_state_flag_q[i];
         fall_evt[i] = channel_on_q[i] && (sync2_q[i] == sync3_q[i])
                       && !sync3_q[i] && result_state_flag_q[i];
      end
   end

   // ************************************************
   // Control register
   // ************************************************
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         channel_on_q <= '0;
         rise_event_flag_q <= '0;
         fall_event_flag_q <= '0;
         for (int i = 0; i < NCH; i++) begin
            pos_hyst_q[i] <= 2'h0;
            neg_hyst_q[i] <= 2'h0;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (sfr_wr_in && ctrl_sel[i]) begin
               channel_on_q[i] <= sfr_wdata_in[`CMPCTL_BIT_EN];
               pos_hyst_q[i] <= sfr_wdata_in[3:2];
               neg_hyst_q[i] <= sfr_wdata_in[1:0];
            end
            // Edge beats a clearing write; only a written 0 clears
            if (rise_evt[i]) begin
               rise_event_flag_q[i] <= 1'b1;
            end else if (sfr_wr_in && ctrl_sel[i] && !sfr_wdata_in[`CMPCTL_BIT_RISE]) begin
               rise_event_flag_q[i] <= 1'b0;
            end
            if (fall_evt[i]) begin
               fall_event_flag_q[i] <= 1'b1;
            end else if (sfr_wr_in && ctrl_sel[i] && !sfr_wdata_in[`CMPCTL_BIT_FALL]) begin
               fall_event_flag_q[i] <= 1'b0;
            end
         end
      end
   end

   // ************************************************
   // Mode register
   // ************************************************
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         rise_irq_enable_q <= '0;
         fall_irq_enable_q <= '0;
         for (int i = 0; i < NCH; i++) begin
            resp_q[i] <= cmpctl_resp_t'(2'(`CMPCTL_MODE_RST));
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (sfr_wr_in && mode_sel[i]) begin
               rise_irq_enable_q[i] <= sfr_wdata_in[`CMPCTL_BIT_RIE];
               fall_irq_enable_q[i] <= sfr_wdata_in[`CMPCTL_BIT_FIE];
               resp_q[i] <= cmpctl_resp_t'(sfr_wdata_in[1:0]);
            end
         end
      end
   end

   // ************************************************
   // Read mux and outputs
   // ************************************************
   always_comb begin
      sfr_rdata_out = 8'h00;
      for (int i = 0; i < NCH; i++) begin
         if (ctrl_sel[i]) begin
            sfr_rdata_out = {channel_on_q[i], result_state_flag_q[i], rise_event_flag_q[i],
                             fall_event_flag_q[i], pos_hyst_q[i], neg_hyst_q[i]};
         end else if (mode_sel[i]) begin
            sfr_rdata_out = {2'b00, rise_irq_enable_q[i], fall_irq_enable_q[i],
                             2'b00, resp_q[i]} & `CMPCTL_MODE_MASK;
         end
      end
   end

   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         positive_hysteresis_sel_out[i] = pos_hyst_q[i];
         negative_hysteresis_sel_out[i] = neg_hyst_q[i];
         response_mode_sel_out[i] = resp_q[i];
      end
   end

   assign channel_on_out = channel_on_q;
   assign pin_out = result_state_flag_q & channel_on_q;
   // Level request; the core sees it only with its extended enable set
   assign irq_out = ((rise_event_flag_q & rise_irq_enable_q)
                    | (fall_event_flag_q & fall_irq_enable_q))
                    & ext_irq_enable_in;
endmodule
